// File: hw/flash_seq_pkg.sv
package flash_seq_pkg;

  // ****************************************************
  // Widths and fixed figures
  // ****************************************************
  localparam int unsigned CLOCK_MHZ = 100;
  localparam int unsigned FIFO_WIDTH = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned ROW_BYTES = 8;
  localparam int unsigned MARKER_BIT = 7;
  localparam int unsigned CTL_BLK_LSB = 5;

  // Timing in microseconds, last three in clock cycles; microsecond cycles follow from bus_speed_param at run time.
  localparam logic [31:0] STEP_US = 32'h0000_000A;
  localparam logic [31:0] HVTV_US = 32'h0000_0005;
  localparam logic [31:0] VTP_US = 32'h0000_0005;
  localparam logic [31:0] HVD_US = 32'h0000_0005;
  localparam logic [31:0] ERASE_UNIT_US = 32'h0000_0018;
  localparam logic [31:0] READ_CYCLES = 32'h0000_0001;
  localparam logic [31:0] MARGIN_EXTRA_CYCLES = 32'h0000_0008;
  localparam logic [31:0] DUMP_BIT_CYCLES = 32'h0000_0020;

  // ****************************************************
  // Protection bounds and erase block masks
  // ****************************************************
  localparam logic [15:0] PROT_BOUND0 = 16'h7800;
  localparam logic [15:0] PROT_BOUND1 = 16'h7880;
  localparam logic [15:0] PROT_BOUND2 = 16'h7900;
  localparam logic [15:0] PROT_BOUND3 = 16'h7A00;
  localparam logic [15:0] PROT_TOP = 16'h7FEF;
  localparam logic [15:0] VECTOR_LOW = 16'hFFF0;
  localparam logic [15:0] MASK_FULL = 16'h07FF;
  localparam logic [15:0] MASK_HALF = 16'h03FF;
  localparam logic [15:0] MASK_ROWS8 = 16'h003F;
  localparam logic [15:0] MASK_ROW = 16'h0007;
  localparam logic [1:0] BLK_ROW = 2'h3;

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [1:0] {
    op_range_read_verify = 2'h0,
    op_range_program = 2'h1,
    op_range_erase = 2'h2,
    op_wear_level_row_program = 2'h3
  } op_t;

  typedef struct packed {
    op_t op;
    logic [15:0] start_address;
    logic [15:0] last_address_param;
    logic [7:0] acc_arg;
    logic [7:0] bus_speed_param;
    logic [7:0] pulse_limit;
    logic [15:0] erase_delay_param;
    logic [7:0] erase_control_byte;
  } cmd_t;

  typedef struct packed {
    logic carry;
    logic interrupt_mask;
    logic [7:0] acc;
    logic [15:0] address;
  } res_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
    logic program_select;
    logic erase_select;
    logic high_voltage_enable;
    logic margin;
    logic pump_on;
    logic [1:0] blk;
  } flash_req_t;

endpackage : flash_seq_pkg

// File: hw/flash_range_sequencer.sv
`timescale 1ns/1ps
// Contract
// - Nonzero accumulator: copy and compare with buffer; zero: dump range on pin.
// - Carry set only if all buffer compares match; accumulator returns checksum.
// - Pin dump sends each byte in monitor format: start, eight bits, stop.
// - Program every byte from start to last from successive buffer bytes.
// - Stop after pulse limit and fail; carry set on success only.
// - Control bits 6:5 select full, half, eight rows or one row erase.
// - Erase high voltage lasts erase delay times 24 microseconds.
// - Erase returns the address argument unchanged.
// - Program, erase and wear-level return with interrupt mask set.
// - Wear levelling always takes eight buffer bytes as the row.
// - Row count is last minus first divided by eight, plus one.
// - Every row written once before any row is written again.
// - Bit 7 of row byte zero is the sequencer's cycling marker.
// - Pick first row whose marker differs from row zero, else row zero.
// - Erase chosen row then program it with its marker inverted.
// - Wait mode in read mode leaves reading unaffected.
// - Wait or stop entry switches the pump off; program, erase and wear-level operations stop advancing.
// - Select plus high voltage at entry stays until reset; vectors blocked.
// - Stop in read mode puts the array into standby.
// - Pulse order: select, protect read, write, high voltage, margin read.
// - Rows are erased before reprogramming; erased bytes read zero.
// - Protected target clears the select bit and blocks high voltage.

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic ready_q;
  wire push = in_valid & ready_q;
  wire pop = out_valid & out_ready;

  assign in_ready = ready_q;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b0;
    end
    else
    begin
      wr_q <= wr_q + AW'(push);
      rd_q <= rd_q + AW'(pop);
      cnt_q <= cnt_d;
      ready_q <= (cnt_d != (AW+1)'(DEPTH));
    end
  end
endmodule : byte_fifo

module flash_range_sequencer
  import flash_seq_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire cmd_t cmd,
  output logic busy,
  output logic done,
  output res_t result,
  input wire logic buf_valid,
  input wire logic [7:0] buf_data,
  output logic buf_ready,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic serial_dump_pin,
  output flash_req_t flash_req,
  input wire logic [7:0] flash_rdata,
  input wire logic [7:0] protect_byte,
  input wire logic wait_mode,
  input wire logic stop_mode,
  output logic flash_standby,
  output logic vector_fetch_blocked
);

  // ****************************************************
  // State and storage
  // ****************************************************
  typedef enum logic [4:0] {
    s_idle = 5'h00, s_rd = 5'h01, s_rd_chk = 5'h03, s_dump = 5'h02,
    s_load = 5'h06, s_scan = 5'h07, s_scan_chk = 5'h05, s_ers_sel = 5'h04,
    s_ers_prot = 5'h0C, s_ers_wr = 5'h0D, s_ers_hv = 5'h0F, s_ers_end = 5'h0E,
    s_pg_fetch = 5'h0A, s_pg_sel = 5'h0B, s_pg_prot = 5'h09, s_pg_wr = 5'h08,
    s_pg_hv = 5'h18, s_pg_hvtv = 5'h19, s_pg_marg = 5'h1B, s_pg_clr = 5'h1A,
    s_pg_mrd = 5'h1E, s_finish = 5'h1F
  } state_t;

  state_t st_q;
  cmd_t c_q;
  flash_req_t fr_q;
  res_t res_q;
  logic [15:0] addr_q;
  logic [12:0] row_q;
  logic [12:0] nrows_q;
  logic m0_q;
  logic [7:0] rowbuf_q [ROW_BYTES];
  logic [2:0] bidx_q;
  logic [7:0] pgdata_q;
  logic [7:0] pulses_q;
  logic [31:0] tmr_q;
  logic ok_q;
  logic [7:0] sum_q;
  logic busy_q;
  logic done_q;
  logic rd_valid_q;
  logic [7:0] rd_data_q;
  logic [8:0] shift_q;
  logic [3:0] bitcnt_q;
  logic pin_q;
  logic stuck_q;
  logic lp_q;
  logic standby_q;
  logic fifo_ov;
  logic [7:0] fifo_d;

  function automatic logic [31:0] us_cycles(input logic [31:0] us, input logic [7:0] spd);
    logic [39:0] p;
    p = ({8'h00, us} * {32'h0000_0000, spd} + 40'h00_0000_0003) >> 2;
    if (p[39:32] != 8'h00)
      return 32'hFFFF_FFFF;
    else if (p[31:0] == 32'h0000_0000)
      return 32'h0000_0001;
    else
      return p[31:0];
  endfunction : us_cycles

  // ****************************************************
  // Decoding
  // ****************************************************
  wire tw = (tmr_q == 32'h0000_0000);
  wire lp = wait_mode | stop_mode;
  wire pe_op = (c_q.op != op_range_read_verify);
  wire run = !stuck_q && !(lp && pe_op);
  wire to_buf = (c_q.acc_arg != 8'h00);
  wire [7:0] spd = c_q.bus_speed_param;
  wire [1:0] blk = (c_q.op == op_wear_level_row_program) ? BLK_ROW : c_q.erase_control_byte[CTL_BLK_LSB+:2];
  wire [15:0] blk_mask = (blk == 2'h0) ? MASK_FULL : (blk == 2'h1) ? MASK_HALF : (blk == 2'h2) ? MASK_ROWS8 : MASK_ROW;
  wire erasing = (st_q == s_ers_prot);
  wire [15:0] chk_lo = erasing ? (addr_q & ~blk_mask) : addr_q;
  wire [15:0] chk_hi = erasing ? (addr_q | blk_mask) : addr_q;
  wire [15:0] prot_bound = protect_byte[0] ? PROT_BOUND0 : protect_byte[1] ? PROT_BOUND1 :
                           protect_byte[2] ? PROT_BOUND2 : PROT_BOUND3;
  wire prot_hit = (|protect_byte[3:0]) && ((chk_hi >= prot_bound && chk_lo <= PROT_TOP) || chk_hi >= VECTOR_LOW);
  wire wear = (c_q.op == op_wear_level_row_program);
  wire want_buf = (st_q == s_load) || (st_q == s_pg_fetch && !wear) || (st_q == s_rd_chk && tw && to_buf);
  wire fifo_pop = run && want_buf && fifo_ov;
  wire last_byte = wear ? (bidx_q == 3'h7) : (addr_q == c_q.last_address_param);
  wire [31:0] erase_us = {16'h0000, c_q.erase_delay_param} * ERASE_UNIT_US;
  wire marker = flash_rdata[MARKER_BIT];
  wire differ = (row_q != 13'h0000) && (marker != m0_q);

  assign busy = busy_q;
  assign done = done_q;
  assign result = res_q;
  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  assign serial_dump_pin = pin_q;
  assign flash_req = fr_q;
  assign flash_standby = standby_q;
  assign vector_fetch_blocked = stuck_q;

  byte_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .resetn(resetn),
    .in_valid(buf_valid),
    .in_data(buf_data),
    .in_ready(buf_ready),
    .out_valid(fifo_ov),
    .out_data(fifo_d),
    .out_ready(fifo_pop)
  );

  // ****************************************************
  // Low-power handling
  // ****************************************************
  // The hung state can only be left through reset, because the array is not in read mode.
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      lp_q <= 1'b0;
      stuck_q <= 1'b0;
      standby_q <= 1'b0;
    end
    else
    begin
      lp_q <= lp;
      if (lp && !lp_q && (fr_q.program_select || fr_q.erase_select) && fr_q.high_voltage_enable)
        stuck_q <= 1'b1;
      standby_q <= stop_mode && !fr_q.program_select && !fr_q.erase_select;
    end
  end

  // ****************************************************
  // Sequencer
  // ****************************************************
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      st_q <= s_idle;
      c_q <= '0;
      fr_q <= '0;
      res_q <= '0;
      addr_q <= '0;
      row_q <= '0;
      nrows_q <= '0;
      m0_q <= 1'b0;
      for (int i = 0; i < ROW_BYTES; i++)
        rowbuf_q[i] <= 8'h00;
      bidx_q <= '0;
      pgdata_q <= '0;
      pulses_q <= '0;
      tmr_q <= '0;
      ok_q <= 1'b0;
      sum_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
      shift_q <= '0;
      bitcnt_q <= '0;
      pin_q <= 1'b1;
    end
    else
    begin
      done_q <= 1'b0;
      rd_valid_q <= 1'b0;
      fr_q.write <= 1'b0;
      fr_q.read <= 1'b0;
      fr_q.pump_on <= !lp;
      if (run && !tw)
        tmr_q <= tmr_q - 32'h0000_0001;
      if (run)
      begin
        case (st_q)
          s_idle:
            if (cmd_valid)
            begin
              c_q <= cmd;
              busy_q <= 1'b1;
              addr_q <= cmd.start_address;
              nrows_q <= 13'((cmd.last_address_param - cmd.start_address) >> 3);
              row_q <= '0;
              bidx_q <= '0;
              sum_q <= '0;
              ok_q <= 1'b1;
              case (cmd.op)
                op_range_read_verify: st_q <= s_rd;
                op_range_program: st_q <= s_pg_fetch;
                op_range_erase: st_q <= s_ers_sel;
                default: st_q <= s_load;
              endcase
            end
          s_rd:
          begin
            fr_q.read <= 1'b1;
            fr_q.addr <= addr_q;
            tmr_q <= READ_CYCLES;
            st_q <= s_rd_chk;
          end
          s_rd_chk:
            if (tw && to_buf && fifo_ov)
            begin
              sum_q <= sum_q + flash_rdata;
              if (flash_rdata != fifo_d)
                ok_q <= 1'b0;
              rd_valid_q <= 1'b1;
              rd_data_q <= flash_rdata;
              addr_q <= addr_q + 16'h0001;
              st_q <= (addr_q == c_q.last_address_param) ? s_finish : s_rd;
            end
            else if (tw && !to_buf)
            begin
              sum_q <= sum_q + flash_rdata;
              pin_q <= 1'b0;
              shift_q <= {1'b1, flash_rdata};
              bitcnt_q <= 4'h9;
              tmr_q <= DUMP_BIT_CYCLES;
              st_q <= s_dump;
            end
          s_dump:
            if (tw)
            begin
              if (bitcnt_q == 4'h0)
              begin
                addr_q <= addr_q + 16'h0001;
                st_q <= (addr_q == c_q.last_address_param) ? s_finish : s_rd;
              end
              else
              begin
                pin_q <= shift_q[0];
                shift_q <= {1'b1, shift_q[8:1]};
                bitcnt_q <= bitcnt_q - 4'h1;
                tmr_q <= DUMP_BIT_CYCLES;
              end
            end
          s_load:
            if (fifo_ov)
            begin
              rowbuf_q[bidx_q] <= fifo_d;
              bidx_q <= bidx_q + 3'h1;
              if (bidx_q == 3'h7)
                st_q <= s_scan;
            end
          s_scan:
          begin
            fr_q.read <= 1'b1;
            fr_q.addr <= addr_q;
            tmr_q <= READ_CYCLES;
            st_q <= s_scan_chk;
          end
          s_scan_chk:
            if (tw)
            begin
              if (row_q == 13'h0000)
                m0_q <= marker;
              if (differ || row_q == nrows_q)
              begin
                rowbuf_q[0][MARKER_BIT] <= ~marker;
                if (!differ)
                  addr_q <= c_q.start_address;
                st_q <= s_ers_sel;
              end
              else
              begin
                row_q <= row_q + 13'h0001;
                addr_q <= addr_q + 16'h0008;
                st_q <= s_scan;
              end
            end
          s_ers_sel:
          begin
            fr_q.erase_select <= 1'b1;
            fr_q.blk <= blk;
            st_q <= s_ers_prot;
          end
          s_ers_prot:
            if (prot_hit)
            begin
              fr_q.erase_select <= 1'b0;
              ok_q <= 1'b0;
              st_q <= s_finish;
            end
            else
              st_q <= s_ers_wr;
          s_ers_wr:
          begin
            fr_q.write <= 1'b1;
            fr_q.addr <= addr_q;
            fr_q.wdata <= 8'h00;
            st_q <= s_ers_hv;
          end
          s_ers_hv:
            if (!fr_q.high_voltage_enable)
            begin
              fr_q.high_voltage_enable <= 1'b1;
              tmr_q <= us_cycles(erase_us, spd);
            end
            else if (tw)
            begin
              fr_q.high_voltage_enable <= 1'b0;
              fr_q.erase_select <= 1'b0;
              tmr_q <= us_cycles(HVD_US, spd);
              st_q <= s_ers_end;
            end
          s_ers_end:
            if (tw)
            begin
              bidx_q <= '0;
              st_q <= wear ? s_pg_fetch : s_finish;
            end
          s_pg_fetch:
            if (wear || fifo_ov)
            begin
              pgdata_q <= wear ? rowbuf_q[bidx_q] : fifo_d;
              pulses_q <= '0;
              st_q <= s_pg_sel;
            end
          s_pg_sel:
          begin
            fr_q.program_select <= 1'b1;
            st_q <= s_pg_prot;
          end
          s_pg_prot:
            if (prot_hit)
            begin
              fr_q.program_select <= 1'b0;
              ok_q <= 1'b0;
              st_q <= s_finish;
            end
            else
              st_q <= s_pg_wr;
          s_pg_wr:
          begin
            fr_q.write <= 1'b1;
            fr_q.addr <= addr_q;
            fr_q.wdata <= pgdata_q;
            st_q <= s_pg_hv;
          end
          s_pg_hv:
            if (!fr_q.high_voltage_enable)
            begin
              fr_q.high_voltage_enable <= 1'b1;
              tmr_q <= us_cycles(STEP_US, spd);
            end
            else if (tw)
            begin
              fr_q.high_voltage_enable <= 1'b0;
              tmr_q <= us_cycles(HVTV_US, spd);
              st_q <= s_pg_hvtv;
            end
          s_pg_hvtv:
            if (tw)
            begin
              fr_q.margin <= 1'b1;
              tmr_q <= us_cycles(VTP_US, spd);
              st_q <= s_pg_marg;
            end
          s_pg_marg:
            if (tw)
            begin
              fr_q.program_select <= 1'b0;
              tmr_q <= us_cycles(HVD_US, spd);
              st_q <= s_pg_clr;
            end
          s_pg_clr:
            if (tw)
            begin
              fr_q.read <= 1'b1;
              fr_q.addr <= addr_q;
              tmr_q <= READ_CYCLES + MARGIN_EXTRA_CYCLES;
              st_q <= s_pg_mrd;
            end
          s_pg_mrd:
            if (tw)
            begin
              fr_q.margin <= 1'b0;
              if (flash_rdata == pgdata_q)
              begin
                addr_q <= addr_q + 16'h0001;
                bidx_q <= bidx_q + 3'h1;
                st_q <= last_byte ? s_finish : s_pg_fetch;
              end
              else if (pulses_q + 8'h01 >= c_q.pulse_limit)
              begin
                ok_q <= 1'b0;
                st_q <= s_finish;
              end
              else
              begin
                pulses_q <= pulses_q + 8'h01;
                st_q <= s_pg_sel;
              end
            end
          s_finish:
          begin
            fr_q.program_select <= 1'b0;
            fr_q.erase_select <= 1'b0;
            fr_q.high_voltage_enable <= 1'b0;
            fr_q.margin <= 1'b0;
            res_q.carry <= ok_q && (pe_op || to_buf);
            res_q.interrupt_mask <= pe_op;
            res_q.acc <= sum_q;
            res_q.address <= c_q.start_address;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            st_q <= s_idle;
          end
          default: st_q <= s_idle;
        endcase
      end
    end
  end

endmodule : flash_range_sequencer

// File: tb/flash_model.sv
`timescale 1ns/1ps
module flash_model
  import flash_seq_pkg::*;
(
  input wire logic clock,
  input wire flash_req_t flash_req,
  input wire logic fail_prog,
  output logic [7:0] flash_rdata
);
  // ************
  // Flash array
  // ************
  logic [7:0] mem [0:2047];
  logic [10:0] waddr_q;
  logic [7:0] wdata_q;
  logic [10:0] raddr_q;
  wire [10:0] ers_mask = (flash_req.blk == 2'h0) ? 11'h7FF : (flash_req.blk == 2'h1) ? 11'h3FF
    : (flash_req.blk == 2'h2) ? 11'h03F : 11'h007;
  // Cells need pumped high voltage, so a blocked select leaves them alone.
  wire hv_on = flash_req.high_voltage_enable && flash_req.pump_on;
  assign flash_rdata = mem[raddr_q];
  always @(posedge clock)
  begin
    if (flash_req.write)
    begin
      waddr_q <= flash_req.addr[10:0];
      wdata_q <= flash_req.wdata;
    end
    if (flash_req.read)
      raddr_q <= flash_req.addr[10:0];
    if (hv_on && flash_req.program_select && !fail_prog)
      mem[waddr_q] <= mem[waddr_q] | wdata_q;
    if (hv_on && flash_req.erase_select)
      for (int i = 0; i < 2048; i++)
        if ((i[10:0] & ~ers_mask) == (waddr_q & ~ers_mask))
          mem[i] <= 8'h00;
  end
endmodule : flash_model

// File: tb/flash_range_sequencer_chk.sv
`timescale 1ns/1ps
module flash_range_sequencer_chk
  import flash_seq_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic busy,
  input wire logic done,
  input wire logic rd_valid,
  input wire logic serial_dump_pin,
  input wire flash_req_t flash_req,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic flash_standby,
  input wire logic vector_fetch_blocked
);
  // ***********
  // Properties
  // ***********
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  a_done_one_cycle: assert property (done |=> !done) else $error("done held");
  a_done_ends_busy: assert property (done |-> !busy) else $error("busy at done");
  a_cmd_taken: assert property (cmd_valid && !busy && !done && !wait_mode && !stop_mode
    && !vector_fetch_blocked |=> busy) else $error("cmd lost");
  a_hv_needs_select: assert property (flash_req.high_voltage_enable |->
    (flash_req.program_select || flash_req.erase_select)) else $error("hv alone");
  a_write_in_select: assert property (flash_req.write |->
    (flash_req.program_select || flash_req.erase_select)) else $error("stray write");
  a_margin_read_order: assert property (flash_req.read && flash_req.margin |->
    !flash_req.program_select && !flash_req.high_voltage_enable) else $error("margin order");
  a_pump_off_lp: assert property ((wait_mode || stop_mode) |=> !flash_req.pump_on) else $error("pump on");
  a_standby_stop: assert property (flash_standby ==
    $past(stop_mode && !flash_req.program_select && !flash_req.erase_select)) else $error("standby");
  a_block_sticky: assert property (vector_fetch_blocked |=> vector_fetch_blocked && !done
    && $stable(flash_req.program_select) && $stable(flash_req.erase_select)) else $error("block lost");
  a_rd_in_busy: assert property (rd_valid |-> busy) else $error("rd idle");
  a_dump_idle_high: assert property (!busy |-> serial_dump_pin) else $error("pin low idle");
endmodule : flash_range_sequencer_chk

bind flash_range_sequencer flash_range_sequencer_chk i_flash_range_sequencer_chk (.clock, .resetn, .cmd_valid,
  .busy, .done, .rd_valid, .serial_dump_pin, .flash_req, .wait_mode, .stop_mode, .flash_standby,
  .vector_fetch_blocked);

// File: tb/flash_range_sequencer_tb.sv
`timescale 1ns/1ps
module flash_range_sequencer_tb
  import flash_seq_pkg::*;
;
  // ***********
  // Bench
  // ***********
  logic clock = 0, resetn = 0, cmd_valid = 0, buf_valid = 0, wait_mode = 0, stop_mode = 0, fail_prog = 0;
  logic [7:0] buf_data = 8'h00, protect_byte = 8'h00, flash_rdata, rd_data, sh, sum;
  logic busy, done, buf_ready, rd_valid, serial_dump_pin, flash_standby, vector_fetch_blocked;
  cmd_t cmd = '0;
  res_t result;
  flash_req_t flash_req;
  int n_errors = 0, samples_checked = 0, cycles = 0, lo, hi;
  res_t res_q[$];
  logic acc_q[$];
  logic [7:0] rd_q[$], dump_q[$], dat[16];
  logic [7:0] ctl_t[5] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h60};
  logic [7:0] prot_t[5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h08};
  logic [15:0] adr_t[5] = '{16'h7C45, 16'h7C45, 16'h7C45, 16'h7850, 16'h7850};
  logic [10:0] msk_t[5] = '{11'h7FF, 11'h3FF, 11'h03F, 11'h007, 11'h007};
  always #5 clock = ~clock;
  flash_range_sequencer i_flash_range_sequencer (.clock, .resetn, .cmd_valid, .cmd, .busy, .done, .result,
    .buf_valid, .buf_data, .buf_ready, .rd_valid, .rd_data, .serial_dump_pin, .flash_req, .flash_rdata,
    .protect_byte, .wait_mode, .stop_mode, .flash_standby, .vector_fetch_blocked);
  flash_model i_flash_model (.clock, .flash_req, .fail_prog, .flash_rdata);
  task automatic end_sim;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic compare_res(input res_t e, input logic chk_acc, input res_t g);
    samples_checked++;
    if (g.carry !== e.carry || g.interrupt_mask !== e.interrupt_mask || g.address !== e.address
        || (chk_acc && g.acc !== e.acc))
    begin
      n_errors++;
      $display("wrong value result expected %h seen %h", e, g);
    end
  endtask : compare_res
  task automatic compare_byte(input string name, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask : compare_byte
  task automatic issue(input op_t op, input logic [15:0] a, l, input logic [7:0] acc, ctl, lim);
    @(negedge clock);
    cmd = '{op, a, l, acc, 8'h08, lim, 16'h0001, ctl};
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
  endtask : issue
  task automatic run_cmd(input op_t op, input logic [15:0] a, l, input logic [7:0] acc, ctl, input logic c,
    input logic [7:0] ea);
    res_q.push_back('{c, op != op_range_read_verify, ea, a});
    acc_q.push_back(op == op_range_read_verify);
    issue(op, a, l, acc, ctl, 8'h03);
    for (int i = 0; i < 30000 && done !== 1'b1; i++)
      @(negedge clock);
    if (done !== 1'b1)
    begin
      n_errors++;
      end_sim();
    end
  endtask : run_cmd
  task automatic push_bytes(input int n);
    buf_valid = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      buf_data = dat[i];
      while (buf_ready !== 1'b1)
        @(negedge clock);
      @(negedge clock);
    end
    buf_valid = 1'b0;
  endtask : push_bytes
  task automatic fill_mem(input logic [7:0] v);
    for (int i = 0; i < 2048; i++)
      i_flash_model.mem[i] = v;
  endtask : fill_mem
  always @(negedge clock)
  begin
    if (resetn && done === 1'b1 && res_q.size() > 0)
      compare_res(res_q.pop_front(), acc_q.pop_front(), result);
    if (resetn && rd_valid === 1'b1 && rd_q.size() > 0)
      compare_byte("rd_data", rd_q.pop_front(), rd_data);
  end
  // Mid-bit sampling tolerates a one-cycle slip in the shifter.
  always
  begin
    @(negedge serial_dump_pin);
    repeat ((DUMP_BIT_CYCLES + 1) / 2) @(posedge clock);
    for (int b = 0; b < 8; b++)
    begin
      repeat (DUMP_BIT_CYCLES + 1) @(posedge clock);
      sh[b] = serial_dump_pin;
    end
    if (dump_q.size() > 0)
      compare_byte("dump", dump_q.pop_front(), sh);
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      n_errors++;
      end_sim();
    end
  end
  initial
  begin
    void'($urandom(61086));
    fill_mem(8'h00);
    repeat (10) @(negedge clock);
    resetn = 1'b1;
    for (int i = 0; i < 16; i++)
      dat[i] = $urandom;
    push_bytes(16);
    compare_byte("buf_ready", 8'h00, {7'h00, buf_ready});
    run_cmd(op_range_program, 16'h7820, 16'h782F, 8'h00, 8'h00, 1'b1, 8'h00);
    sum = 8'h00;
    for (int i = 0; i < 16; i++)
    begin
      compare_byte("mem", dat[i], i_flash_model.mem[11'h020 + i]);
      rd_q.push_back(dat[i]);
      sum += dat[i];
    end
    push_bytes(16);
    run_cmd(op_range_read_verify, 16'h7820, 16'h782F, 8'hFF, 8'h00, 1'b1, sum);
    dump_q.push_back(dat[0]);
    dump_q.push_back(dat[1]);
    run_cmd(op_range_read_verify, 16'h7820, 16'h7821, 8'h00, 8'h00, 1'b0, dat[0] + dat[1]);
    for (int i = 0; i < 16; i++)
      rd_q.push_back(dat[i]);
    dat[5] = dat[5] ^ 8'h10;
    push_bytes(16);
    wait_mode = 1'b1;
    run_cmd(op_range_read_verify, 16'h7820, 16'h782F, 8'h01, 8'h00, 1'b0, sum);
    wait_mode = 1'b0;
    for (int k = 0; k < 5; k++)
    begin
      fill_mem(8'hFF);
      protect_byte = prot_t[k];
      run_cmd(op_range_erase, adr_t[k], 16'h0000, 8'h00, ctl_t[k], k != 3, 8'h00);
      lo = int'(adr_t[k][10:0] & ~msk_t[k]);
      hi = int'(adr_t[k][10:0] | msk_t[k]);
      compare_byte("erase_lo", (k != 3) ? 8'h00 : 8'hFF, i_flash_model.mem[lo]);
      compare_byte("erase_hi", (k != 3) ? 8'h00 : 8'hFF, i_flash_model.mem[hi]);
      if (hi < 2047)
        compare_byte("erase_out", 8'hFF, i_flash_model.mem[hi + 1]);
    end
    protect_byte = 8'h00;
    fill_mem(8'h00);
    fail_prog = 1'b1;
    dat[0] = $urandom | 8'h01;
    push_bytes(1);
    run_cmd(op_range_program, 16'h7858, 16'h7858, 8'h00, 8'h00, 1'b0, 8'h00);
    fail_prog = 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      for (int i = 0; i < 8; i++)
        dat[i] = $urandom;
      push_bytes(8);
      run_cmd(op_wear_level_row_program, 16'h7880, 16'h7888, 8'h00, 8'h00, 1'b1, 8'h00);
      for (int i = 0; i < 8; i++)
        compare_byte("row", (i == 0) ? {k < 2, dat[0][6:0]} : dat[i],
          i_flash_model.mem[11'h080 + 8 * (k % 2) + i]);
    end
    stop_mode = 1'b1;
    repeat (2) @(negedge clock);
    compare_byte("standby", 8'h01, {7'h00, flash_standby});
    stop_mode = 1'b0;
    issue(op_range_erase, 16'h7900, 16'h0000, 8'h00, 8'h60, 8'h03);
    for (int i = 0; i < 2000 && flash_req.high_voltage_enable !== 1'b1; i++)
      @(negedge clock);
    wait_mode = 1'b1;
    repeat (3) @(negedge clock);
    compare_byte("blocked", 8'h01, {7'h00, vector_fetch_blocked});
    compare_byte("pump", 8'h00, {7'h00, flash_req.pump_on});
    resetn = 1'b0;
    wait_mode = 1'b0;
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    @(negedge clock);
    compare_byte("blocked", 8'h00, {7'h00, vector_fetch_blocked});
    end_sim();
  end
endmodule : flash_range_sequencer_tb
